// ---- rtl/cgr_regs.sv ----
`timescale 1ns/10ps
module cgr_regs
    import cgr_pkg::*;
#(
    parameter logic [3:0] REV_CODE  = 4'h5,  // arbitrary value
    parameter logic [3:0] VEND_CODE = 4'hA,  // arbitrary value
    parameter logic [1:0] DEV_CLASS = 2'h0,  // clock generator
    parameter logic [5:0] DEV_CODE  = 6'h15  // arbitrary value
) (
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_scl,
    input  wire logic       i_sda,
    output logic            o_sda,
    output logic            o_sda_oe_n,
    input  wire logic       i_addr_strap,
    input  wire logic [1:0] i_spread_strap,
    input  wire logic [1:0] i_out_en_n,
    input  wire logic       i_power_down,
    input  wire logic [1:0] i_stop_state,
    output logic [1:0]      o_diff_run,
    output logic            o_diff_stop_true,
    output logic            o_diff_stop_comp,
    output logic            o_diff_stop_hiz,
    output logic [1:0]      o_spread_amount,
    output logic [1:0]      o_swing_sel,
    output logic [1:0]      o_out_fast_edge,
    output logic [1:0]      o_ref_edge_rate,
    output logic            o_ref_run,
    output logic            o_ref_stop_high,
    output logic            o_ref_stop_hiz
);
    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    localparam int NPIN = 5;
    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] s1_q;
    logic [NPIN-1:0] s2_q;
    logic [NPIN-1:0] s3_q;
    logic [NPIN-1:0] flt_q;
    logic            scl_prev_q;
    logic            sda_prev_q;
    assign pin_raw = {i_power_down, i_out_en_n, i_sda, i_scl};
    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi++) begin : g_sync
            always_ff @(posedge i_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    s1_q[gi]  <= 1'b1;
                    s2_q[gi]  <= 1'b1;
                    s3_q[gi]  <= 1'b1;
                    flt_q[gi] <= 1'b1;
                end else begin
                    s1_q[gi] <= pin_raw[gi];
                    s2_q[gi] <= s1_q[gi];
                    s3_q[gi] <= s2_q[gi];
                    if (s2_q[gi] == s3_q[gi]) begin
                        flt_q[gi] <= s2_q[gi];
                    end
                end
            end
        end
    endgenerate
    logic       scl_f;
    logic       sda_f;
    logic [1:0] oe_pin_n_f;
    logic       pd_f;
    assign scl_f      = flt_q[0];
    assign sda_f      = flt_q[1];
    assign oe_pin_n_f = flt_q[3:2];
    assign pd_f       = flt_q[4];
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end else begin
            scl_prev_q <= scl_f;
            sda_prev_q <= sda_f;
        end
    end
    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    assign scl_rise  = scl_f & ~scl_prev_q;
    assign scl_fall  = ~scl_f & scl_prev_q;
    assign bus_start = scl_f & scl_prev_q & sda_prev_q & ~sda_f;
    assign bus_stop  = scl_f & scl_prev_q & ~sda_prev_q & sda_f;
    // ----------------------------------------
    // strap capture after reset release
    // ----------------------------------------
    logic       strap_done_q;
    logic       addr_strap_q;
    logic [1:0] spread_rb_q;
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            strap_done_q <= 1'b0;
            addr_strap_q <= 1'b0;
            spread_rb_q  <= 2'h0;
        end else if (!strap_done_q) begin
            strap_done_q <= 1'b1;
            addr_strap_q <= i_addr_strap;
            spread_rb_q  <= i_spread_strap;
        end
    end
    // ----------------------------------------
    // register bytes
    // ----------------------------------------
    logic [1:0] oe_bits_q;
    logic       sw_sel_q;
    logic [1:0] sw_spread_q;
    logic [1:0] swing_q;
    logic [1:0] slew_q;
    logic [1:0] ref_slew_q;
    logic       pd_run_q;
    logic       ref_oe_q;
    logic       wr_stb_q;
    logic [7:0] wr_ptr_q;
    logic [7:0] wr_data_q;
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            oe_bits_q   <= CGR_OE_RST;
            sw_sel_q    <= CGR_SWSEL_RST;
            sw_spread_q <= CGR_SWSPR_RST;
            swing_q     <= CGR_SWING_RST;
            slew_q      <= CGR_SLEW_RST;
            ref_slew_q  <= CGR_RSLEW_RST;
            pd_run_q    <= CGR_PDRUN_RST;
            ref_oe_q    <= CGR_REFOE_RST;
        end else if (wr_stb_q) begin
            case (wr_ptr_q)
                CGR_OFS_OE: begin
                    oe_bits_q <= wr_data_q[CGR_OE_POS +: 2];
                end
                CGR_OFS_SPREAD: begin
                    sw_sel_q    <= wr_data_q[CGR_SWSEL_POS];
                    sw_spread_q <= wr_data_q[CGR_SWSPR_POS +: 2];
                    swing_q     <= wr_data_q[CGR_SWING_POS +: 2];
                end
                CGR_OFS_SLEW: begin
                    slew_q <= wr_data_q[CGR_SLEW_POS +: 2];
                end
                CGR_OFS_REF: begin
                    ref_slew_q <= wr_data_q[CGR_RSLEW_POS +: 2];
                    pd_run_q   <= wr_data_q[CGR_PDRUN_POS];
                    ref_oe_q   <= wr_data_q[CGR_REFOE_POS];
                end
                default: ;
            endcase
        end
    end
    function automatic logic [7:0] rd_byte(input logic [7:0] ptr);
        case (ptr)
            CGR_OFS_OE:      rd_byte = {5'h00, oe_bits_q, 1'b0};
            CGR_OFS_SPREAD:  rd_byte = {spread_rb_q, sw_sel_q, sw_spread_q, 1'b1, swing_q};
            CGR_OFS_SLEW:    rd_byte = {5'h1F, slew_q, 1'b1};
            CGR_OFS_REF:     rd_byte = {ref_slew_q, pd_run_q, ref_oe_q, 4'hF};
            CGR_OFS_RSVD4:   rd_byte = CGR_RSVD4_VAL;
            CGR_OFS_REVVEN:  rd_byte = {REV_CODE, VEND_CODE};
            CGR_OFS_DEVTYPE: rd_byte = {DEV_CLASS, DEV_CODE};
            default:         rd_byte = 8'h00;
        endcase
    endfunction : rd_byte
    // ----------------------------------------
    // smbus block engine
    // ----------------------------------------
    cgr_state_t st_q;
    cgr_state_t nxt_q;
    logic [3:0] cnt_q;
    logic [7:0] sh_q;
    logic [7:0] ptr_q;
    logic [7:0] wleft_q;
    logic       ack_q;
    logic       mack_q;
    logic       drv_q;
    logic       tx;
    logic       active;
    logic [7:0] rd_now;
    assign tx     = (st_q == CGR_ST_RCNT) || (st_q == CGR_ST_RDATA);
    assign active = (st_q != CGR_ST_IDLE) && (st_q != CGR_ST_IGN);
    always_comb rd_now = rd_byte(ptr_q);
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_q      <= CGR_ST_IDLE;
            nxt_q     <= CGR_ST_IDLE;
            cnt_q     <= 4'h0;
            sh_q      <= 8'h00;
            ptr_q     <= 8'h00;
            wleft_q   <= 8'h00;
            ack_q     <= 1'b0;
            mack_q    <= 1'b0;
            drv_q     <= 1'b0;
            wr_stb_q  <= 1'b0;
            wr_ptr_q  <= 8'h00;
            wr_data_q <= 8'h00;
        end else begin
            wr_stb_q <= 1'b0;
            if (bus_start) begin
                st_q  <= CGR_ST_ADDR;
                cnt_q <= 4'h0;
                ack_q <= 1'b0;
                drv_q <= 1'b0;
            end else if (bus_stop) begin
                st_q  <= CGR_ST_IDLE;
                ack_q <= 1'b0;
                drv_q <= 1'b0;
            end else if (scl_rise && active) begin
                if (tx) begin
                    if (cnt_q < 4'h8) begin
                        cnt_q <= cnt_q + 4'h1;
                    end else begin
                        ack_q  <= 1'b1;
                        mack_q <= ~sda_f;
                    end
                end else if (cnt_q < 4'h8) begin
                    sh_q  <= {sh_q[6:0], sda_f};
                    cnt_q <= cnt_q + 4'h1;
                end
            end else if (scl_fall && active) begin
                if (ack_q) begin
                    ack_q <= 1'b0;
                    cnt_q <= 4'h0;
                    drv_q <= 1'b0;
                    if (tx && !mack_q) begin
                        // host nack ends the read
                        st_q <= CGR_ST_IGN;
                    end else if (tx) begin
                        st_q  <= CGR_ST_RDATA;
                        sh_q  <= rd_now;
                        drv_q <= ~rd_now[7];
                        ptr_q <= ptr_q + 8'h01;
                    end else if (nxt_q == CGR_ST_RCNT) begin
                        st_q  <= CGR_ST_RCNT;
                        sh_q  <= CGR_RD_COUNT;
                        drv_q <= ~CGR_RD_COUNT[7];
                    end else begin
                        st_q <= nxt_q;
                    end
                end else if (tx) begin
                    drv_q <= (cnt_q < 4'h8) ? ~sh_q[3'(4'h7 - cnt_q)] : 1'b0;
                end else if (cnt_q == 4'h8) begin
                    ack_q <= 1'b1;
                    drv_q <= 1'b1;
                    case (st_q)
                        CGR_ST_ADDR: begin
                            if (sh_q[7:1] == {CGR_ADDR_HI, addr_strap_q, 1'b0}) begin
                                nxt_q <= sh_q[0] ? CGR_ST_RCNT : CGR_ST_LOC;
                            end else begin
                                nxt_q <= CGR_ST_IGN;
                                drv_q <= 1'b0;
                            end
                        end
                        CGR_ST_LOC: begin
                            ptr_q <= sh_q;
                            nxt_q <= CGR_ST_WCNT;
                        end
                        CGR_ST_WCNT: begin
                            wleft_q <= sh_q;
                            nxt_q   <= CGR_ST_WDATA;
                        end
                        default: begin
                            if (wleft_q != 8'h00) begin
                                wr_stb_q  <= 1'b1;
                                wr_ptr_q  <= ptr_q;
                                wr_data_q <= sh_q;
                                ptr_q     <= ptr_q + 8'h01;
                                wleft_q   <= wleft_q - 8'h01;
                                nxt_q     <= CGR_ST_WDATA;
                            end else begin
                                nxt_q <= CGR_ST_IGN;
                                drv_q <= 1'b0;
                            end
                        end
                    endcase
                end
            end
        end
    end

    // ----------------------------------------
    // control outputs
    // ----------------------------------------
    logic [1:0] spread_code;
    logic [1:0] spread_d;
    // spread source select
    // readback 01 and 10 enter swapped so they share the software decode
    assign spread_code = sw_sel_q ? sw_spread_q : {spread_rb_q[0], spread_rb_q[1]};
    assign spread_d = !spread_code[0] ? CGR_SPR_OFF : (spread_code[1] ? CGR_SPR_H : CGR_SPR_Q);
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_sda            <= 1'b0;
            o_sda_oe_n       <= 1'b1;
            o_diff_run       <= 2'h0;
            o_diff_stop_true <= 1'b0;
            o_diff_stop_comp <= 1'b0;
            o_diff_stop_hiz  <= 1'b0;
            o_spread_amount  <= CGR_SPR_OFF;
            o_swing_sel      <= CGR_SWING_RST;
            o_out_fast_edge  <= CGR_SLEW_RST;
            o_ref_edge_rate  <= CGR_RSLEW_RST;
            o_ref_run        <= 1'b0;
            o_ref_stop_high  <= 1'b0;
            o_ref_stop_hiz   <= 1'b0;
        end else begin
            o_sda      <= 1'b0;
            o_sda_oe_n <= ~drv_q;
            o_diff_run <= oe_bits_q & ~oe_pin_n_f;
            o_diff_stop_true <= (i_stop_state == 2'h2);
            o_diff_stop_comp <= (i_stop_state == 2'h3);
            o_diff_stop_hiz  <= (i_stop_state == 2'h1);
            o_spread_amount  <= spread_d;
            o_swing_sel <= swing_q;
            o_out_fast_edge <= slew_q;
            o_ref_edge_rate <= ref_slew_q;
            o_ref_run <= ref_oe_q & (~pd_f | pd_run_q);
            o_ref_stop_high <= (i_stop_state == 2'h3);
            o_ref_stop_hiz  <= (i_stop_state == 2'h1);
        end
    end
endmodule : cgr_regs

// ---- rtl/cgr_pkg.sv ----
package cgr_pkg;
    localparam logic [7:0] CGR_OFS_OE      = 8'h00;
    localparam logic [7:0] CGR_OFS_SPREAD  = 8'h01;
    localparam logic [7:0] CGR_OFS_SLEW    = 8'h02;
    localparam logic [7:0] CGR_OFS_REF     = 8'h03;
    localparam logic [7:0] CGR_OFS_RSVD4   = 8'h04;
    localparam logic [7:0] CGR_OFS_REVVEN  = 8'h05;
    localparam logic [7:0] CGR_OFS_DEVTYPE = 8'h06;

    localparam int CGR_OE_POS     = 1;
    localparam int CGR_SWSEL_POS  = 5;
    localparam int CGR_SWSPR_POS  = 3;
    localparam int CGR_SWING_POS  = 0;
    localparam int CGR_SLEW_POS   = 1;
    localparam int CGR_RSLEW_POS  = 6;
    localparam int CGR_PDRUN_POS  = 5;
    localparam int CGR_REFOE_POS  = 4;

    localparam logic [1:0] CGR_OE_RST     = 2'h3;
    localparam logic       CGR_SWSEL_RST  = 1'b0;
    localparam logic [1:0] CGR_SWSPR_RST  = 2'h0;
    localparam logic [1:0] CGR_SWING_RST  = 2'h2;
    localparam logic [1:0] CGR_SLEW_RST   = 2'h3;
    localparam logic [1:0] CGR_RSLEW_RST  = 2'h1;
    localparam logic       CGR_PDRUN_RST  = 1'b0;
    localparam logic       CGR_REFOE_RST  = 1'b1;
    localparam logic [7:0] CGR_RSVD4_VAL  = 8'h40;

    // bus address is 1101_0, strap bit, 0
    localparam logic [4:0] CGR_ADDR_HI    = 5'h1A;
    localparam logic [7:0] CGR_RD_COUNT   = 8'h08;

    // spread amount presented to the analog side
    localparam logic [1:0] CGR_SPR_OFF    = 2'h0;
    localparam logic [1:0] CGR_SPR_Q      = 2'h1;
    localparam logic [1:0] CGR_SPR_H      = 2'h2;

    typedef enum logic [2:0] {
        CGR_ST_IDLE  = 3'h0,
        CGR_ST_ADDR  = 3'h1,
        CGR_ST_LOC   = 3'h3,
        CGR_ST_WCNT  = 3'h2,
        CGR_ST_WDATA = 3'h6,
        CGR_ST_RCNT  = 3'h7,
        CGR_ST_RDATA = 3'h5,
        CGR_ST_IGN   = 3'h4
    } cgr_state_t;
endpackage : cgr_pkg

// ---- tb/cgr_regs_monitor.sv ----
`timescale 1ns/10ps
module cgr_regs_monitor
    import cgr_pkg::*;
(
    input wire logic       i_clk,
    input wire logic       i_rst_n,
    input wire logic       i_scl,
    input wire logic [1:0] i_out_en_n,
    input wire logic [1:0] i_stop_state,
    input wire logic       o_sda,
    input wire logic       o_sda_oe_n,
    input wire logic [1:0] o_diff_run,
    input wire logic       o_diff_stop_true,
    input wire logic       o_diff_stop_comp,
    input wire logic       o_diff_stop_hiz,
    input wire logic [1:0] o_spread_amount,
    input wire logic [1:0] o_swing_sel,
    input wire logic [1:0] o_out_fast_edge,
    input wire logic [1:0] o_ref_edge_rate,
    input wire logic       o_ref_stop_high,
    input wire logic       o_ref_stop_hiz
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    // ----------------------------------------
    // sequences
    // ----------------------------------------
    sequence s_pin_off(int k);
        i_out_en_n[k] [*8];
    endsequence
    sequence s_stop_steady;
        $stable(i_stop_state) [*4];
    endsequence

    AST_OUT0_PIN_OFF: assert property (s_pin_off(0) |-> ##1 !o_diff_run[0])
        else $error("output 0 runs with its enable pin off");
    AST_OUT1_PIN_OFF: assert property (s_pin_off(1) |-> ##1 !o_diff_run[1])
        else $error("output 1 runs with its enable pin off");
    AST_DIFF_STOP_LEVEL: assert property (s_stop_steady |-> {o_diff_stop_true, o_diff_stop_comp,
        o_diff_stop_hiz} == {i_stop_state == 2'h2, i_stop_state == 2'h3, i_stop_state == 2'h1})
        else $error("differential stop level does not match stop field");
    AST_REF_STOP_LEVEL: assert property (s_stop_steady |-> {o_ref_stop_high, o_ref_stop_hiz} ==
        {i_stop_state == 2'h3, i_stop_state == 2'h1})
        else $error("reference stop level does not match stop field");
    AST_SDA_OPEN_DRAIN: assert property (!o_sda_oe_n |-> !o_sda)
        else $error("data pin driven high");
    AST_SDA_SCL_LOW: assert property ($changed(o_sda_oe_n) |-> !$past(i_scl, 2))
        else $error("data drive changed while bus clock high");
    AST_RST_SWING: assert property ($rose(i_rst_n) |-> o_swing_sel == CGR_SWING_RST)
        else $error("swing select reset value wrong");
    AST_RST_EDGES: assert property ($rose(i_rst_n) |-> o_out_fast_edge == CGR_SLEW_RST &&
        o_ref_edge_rate == CGR_RSLEW_RST)
        else $error("edge rate reset values wrong");
    AST_RST_SPREAD: assert property ($rose(i_rst_n) |-> o_spread_amount == CGR_SPR_OFF && o_sda_oe_n)
        else $error("spread or data drive wrong at reset release");
endmodule : cgr_regs_monitor

bind cgr_regs cgr_regs_monitor u_mon (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_scl(i_scl), .i_out_en_n(i_out_en_n), .i_stop_state(i_stop_state),
    .o_sda(o_sda), .o_sda_oe_n(o_sda_oe_n), .o_diff_run(o_diff_run), .o_diff_stop_true(o_diff_stop_true),
    .o_diff_stop_comp(o_diff_stop_comp), .o_diff_stop_hiz(o_diff_stop_hiz), .o_spread_amount(o_spread_amount),
    .o_swing_sel(o_swing_sel), .o_out_fast_edge(o_out_fast_edge), .o_ref_edge_rate(o_ref_edge_rate),
    .o_ref_stop_high(o_ref_stop_high), .o_ref_stop_hiz(o_ref_stop_hiz));

// ---- tb/cgr_smbus_host.sv ----
`timescale 1ns/10ps
module cgr_smbus_host (
    input  wire logic i_clk,
    input  wire logic i_sda,
    output logic      o_scl,
    output logic      o_sda_pull
);
    // clock phase length in cycles, raised for a slow host
    int half = 12;

    initial begin
        o_scl = 1'b1;
        o_sda_pull = 1'b0;
    end
    task automatic hold(input int n);
        repeat (n) @(negedge i_clk);
    endtask : hold
    task automatic start();
        o_sda_pull = 1'b0;
        hold(half);
        o_scl = 1'b1;
        hold(half);
        o_sda_pull = 1'b1;
        hold(half);
        o_scl = 1'b0;
        hold(2);
    endtask : start
    task automatic stop();
        o_sda_pull = 1'b1;
        hold(half);
        o_scl = 1'b1;
        hold(half);
        o_sda_pull = 1'b0;
        hold(half);
    endtask : stop
    task automatic bit_io(input logic b, output logic r);
        o_sda_pull = !b;
        hold(half);
        o_scl = 1'b1;
        hold(half);
        r = i_sda;
        o_scl = 1'b0;
        hold(2);
    endtask : bit_io
    task automatic send(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(b[i], r);
        end
        bit_io(1'b1, r);
        ack = !r;
    endtask : send
    task automatic recv(input logic last, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            b[i] = r;
        end
        bit_io(last, r);
    endtask : recv
endmodule : cgr_smbus_host

// ---- tb/clock_gen_smbus_config_regs_tb.sv ----
`timescale 1ns/10ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin error_cnt++; \
    $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module clock_gen_smbus_config_regs_tb
    import cgr_pkg::*;
    ;
    localparam logic [7:0] RW_MASK [8] = '{8'h06, 8'h3B, 8'h06, 8'hF0, 8'h00, 8'h00, 8'h00, 8'h00};
    logic       clk = 1'b0;
    logic       rst_n, pd, adr_bit, scl, pull, sda_oe_n, sda_o;
    logic [1:0] en_n, stop_st, diff_run, spread, swing, fast, redge, ss_strap;
    logic       s_true, s_comp, s_hiz, ref_run, r_high, r_hiz;
    logic [7:0] exp_reg [8];
    int         error_cnt = 0, compares = 0, cycles = 0;
    wire        sda = !((!sda_oe_n && !sda_o) || pull);

    // identity parameter values are arbitrary
    cgr_regs #(.REV_CODE(4'h6), .VEND_CODE(4'h9), .DEV_CLASS(2'h0), .DEV_CODE(6'h2A)) u_dut (
        .i_clk(clk), .i_rst_n(rst_n), .i_scl(scl), .i_sda(sda), .o_sda(sda_o), .o_sda_oe_n(sda_oe_n),
        .i_addr_strap(1'b1), .i_spread_strap(ss_strap), .i_out_en_n(en_n), .i_power_down(pd),
        .i_stop_state(stop_st), .o_diff_run(diff_run), .o_diff_stop_true(s_true), .o_diff_stop_comp(s_comp),
        .o_diff_stop_hiz(s_hiz), .o_spread_amount(spread), .o_swing_sel(swing), .o_out_fast_edge(fast),
        .o_ref_edge_rate(redge), .o_ref_run(ref_run), .o_ref_stop_high(r_high), .o_ref_stop_hiz(r_hiz));
    cgr_smbus_host u_host (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_pull(pull));

    always #2 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            error_cnt++;
            give_verdict();
        end
    end

    // ----------------------------------------
    // expectations and bus tasks
    // ----------------------------------------
    function automatic logic [1:0] spr(input logic [7:0] b);
        logic [1:0] c;
        c = b[5] ? b[4:3] : {b[6], b[7]};
        return c[0] ? (c[1] ? CGR_SPR_H : CGR_SPR_Q) : CGR_SPR_OFF;
    endfunction : spr
    task automatic chk_out();
        repeat (10) @(negedge clk);
        `CHK(diff_run, exp_reg[0][2:1] & ~en_n)
        `CHK(spread, spr(exp_reg[1]))
        `CHK(swing, exp_reg[1][1:0])
        `CHK(fast, exp_reg[2][2:1])
        `CHK(redge, exp_reg[3][7:6])
        `CHK(ref_run, exp_reg[3][4] & (!pd | exp_reg[3][5]))
    endtask : chk_out
    task automatic do_reset();
        rst_n = 1'b0;
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        // strap level reads back in bits 7:6, identity bytes follow the parameters
        exp_reg = '{8'h06, {ss_strap, 6'h06}, 8'hFF, 8'h5F, 8'h40, 8'h69, 8'h2A, 8'h00};
        repeat (20) @(negedge clk);
    endtask : do_reset
    task automatic wr(input logic [7:0] loc, input int x, input int n, input logic [7:0] d [8]);
        logic ack;
        u_host.start();
        u_host.send({CGR_ADDR_HI, adr_bit, 2'b00}, ack);
        `CHK(ack, adr_bit)
        if (ack) begin
            u_host.send(loc, ack);
            u_host.send(8'(x), ack);
            for (int i = 0; i < n; i++) begin
                u_host.send(d[i], ack);
                `CHK(ack, 1'(i < x))
                if (i < x) begin
                    exp_reg[3'(loc + 8'(i))] = (exp_reg[3'(loc + 8'(i))] & ~RW_MASK[3'(loc + 8'(i))]) |
                        (d[i] & RW_MASK[3'(loc + 8'(i))]);
                end
            end
        end
        u_host.stop();
    endtask : wr
    task automatic rd(input logic [7:0] loc, input int n);
        logic       ack;
        logic [7:0] b;
        u_host.start();
        u_host.send({CGR_ADDR_HI, 3'b100}, ack);
        u_host.send(loc, ack);
        u_host.start();
        u_host.send({CGR_ADDR_HI, 3'b101}, ack);
        u_host.recv(1'b0, b);
        `CHK(b, CGR_RD_COUNT)
        for (int i = 0; i < n; i++) begin
            u_host.recv(i == n - 1, b);
            `CHK(b, exp_reg[3'(loc + 8'(i))])
        end
        u_host.stop();
    endtask : rd
    task automatic give_verdict();
        $display("errors=%0d compares=%0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : give_verdict

    // ----------------------------------------
    // stimulus
    // ----------------------------------------
    initial begin
        en_n = 2'h0;
        pd = 1'b0;
        stop_st = 2'h0;
        adr_bit = 1'b1;
        ss_strap = 2'h2;
        do_reset();
        chk_out();
        rd(8'h00, 8);
        en_n = 2'h2;
        chk_out();
        for (int i = 0; i < 4; i++) begin
            wr(8'h01, 1, 1, '{0: {3'h1, 2'(i), 1'b0, 2'(i)}, default: 8'h00});
            chk_out();
        end
        wr(8'h01, 1, 1, '{0: 8'h19, default: 8'h00});
        chk_out();
        ss_strap = 2'h3;
        do_reset();
        for (int i = 0; i < 4; i++) begin
            wr(8'h03, 1, 1, '{0: {2'(i), 6'h30}, default: 8'h00});
            pd = i[0];
            chk_out();
        end
        wr(8'h03, 1, 1, '{0: 8'h50, default: 8'h00});
        chk_out();
        pd = 1'b0;
        en_n = 2'h1;
        wr(8'h00, 7, 7, '{8'hF9, 8'h39, 8'h00, 8'hE0, 8'h00, 8'hFF, 8'hFF, 8'h00});
        chk_out();
        rd(8'h00, 8);
        wr(8'h02, 1, 2, '{0: 8'h06, default: 8'h00});
        u_host.half = 30;
        rd(8'h02, 2);
        u_host.half = 12;
        adr_bit = 1'b0;
        wr(8'h00, 1, 1, '{0: 8'h06, default: 8'h00});
        adr_bit = 1'b1;
        rd(8'h00, 1);
        for (int i = 0; i < 4; i++) begin
            stop_st = 2'(i);
            repeat (10) @(negedge clk);
            `CHK({s_true, s_comp, s_hiz}, {i == 2, i == 3, i == 1})
            `CHK({r_high, r_hiz}, {i == 3, i == 1})
        end
        give_verdict();
    end
endmodule : clock_gen_smbus_config_regs_tb
